// ==== include/fslg_pkg.sv ====
package fslg_pkg;

  // register indices as printed; the byte address is four times the index
  localparam logic [7:0] OPTION_IDX = 8'h05;
  localparam logic [7:0] PROTECT_IDX = 8'h07;
  localparam logic [7:0] ERASE_CTRL_IDX = 8'h08;
  localparam logic [7:0] STATUS_IDX = 8'h09;
  localparam int ADDR_W = 12;
  localparam int IDX_LSB = 2;

  // option byte layout
  localparam int KEEP_BIT = 3;
  localparam int BOD_LSB = 0;
  localparam int BOD_MSB = 2;
  localparam int OPT_STORE_MSB = 5;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [1:0] OPTION_RESERVED = 2'h3;

  // protection byte layout
  localparam int BOOT_LSB = 6;
  localparam int APP_LSB = 4;
  localparam int TABLE_LSB = 2;
  localparam int EXT_LSB = 0;
  localparam logic [7:0] PROTECT_RESET = 8'hff;
  localparam logic [7:0] PROTECT_SW_MASK = 8'hfc;
  localparam logic [7:0] PROTECT_EXT_MASK = 8'h03;

  // guard field bits: bit 0 low blocks stores, bit 1 low blocks loads
  localparam int STORE_OK_BIT = 0;
  localparam int LOAD_OK_BIT = 1;
  localparam logic [1:0] UNLOCKED_SETTING = 2'h3;
  localparam logic [1:0] WRITE_BLOCKED_SETTING = 2'h2;
  localparam logic [1:0] READ_BLOCKED_SETTING = 2'h1;
  localparam logic [1:0] READ_WRITE_BLOCKED_SETTING = 2'h0;

  // control and status bits
  localparam int ERASE_GO_BIT = 0;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_PEND_BIT = 1;
  localparam int ST_KEEP_BIT = 2;

  // timing
  localparam int CLK_MHZ = 100;
  localparam int KEEP_TIMEOUT_NS = 1000;
  localparam int ERASE_TIME_NS = 2000;
  localparam int KEEP_TIMEOUT_CYC = (KEEP_TIMEOUT_NS * CLK_MHZ + 999) / 1000;
  localparam int ERASE_CYC = (ERASE_TIME_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 16;

  // target section of a program-memory access
  localparam logic [1:0] SEC_APP = 2'h0;
  localparam logic [1:0] SEC_TABLE = 2'h1;
  localparam logic [1:0] SEC_BOOT = 2'h2;

  typedef enum logic [1:0] {
    ERASE_IDLE,
    ERASE_RUN,
    ERASE_DONE
  } fslg_erase_t;

endpackage : fslg_pkg

// ==== rtl/fslg_guard.sv ====
`timescale 1ns/100ps
module fslg_guard (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [fslg_pkg::ADDR_W-1:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  // programming interface owns the bus when high
  input wire logic prog_if_active,
  // core program-memory access check
  input wire logic acc_valid,
  input wire logic acc_store,
  input wire logic [1:0] acc_target,
  input wire logic exec_in_boot,
  input wire logic ivec_in_boot,
  output logic acc_done,
  output logic acc_allow,
  output logic irq_mask,
  // erase and option outputs
  output logic erase_flash,
  output logic erase_eeprom,
  output logic erase_busy,
  output logic [2:0] brownout_threshold_sel,
  output logic [1:0] external_access_guard
);

  // stored option bits 5:0 and protection byte
  logic [fslg_pkg::OPT_STORE_MSB:0] option_store;
  logic [7:0] section_protection_fuses;
  // keep value that erase actually uses
  logic keep_live;
  logic keep_pending;
  logic [fslg_pkg::CNT_W-1:0] keep_cnt;
  // erase sequencer
  fslg_pkg::fslg_erase_t erase_state;
  logic [fslg_pkg::CNT_W-1:0] erase_cnt;
  logic erase_keep;
  // bus data phase capture
  logic dp_write;
  logic [7:0] dp_idx;
  // guard field views
  logic [1:0] boot_area_guard;
  logic [1:0] app_area_guard;
  logic [1:0] app_table_guard;
  logic [1:0] target_guard;
  logic next_allow;
  logic next_mask;
  logic addr_phase;
  logic [7:0] ap_idx;
  logic [31:0] next_rdata;

  // zero wait states, always okay
  // every register answers within one cycle, so the slave never stretches a transfer
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;

  assign addr_phase = hsel & htrans[1] & hready;
  // word index; the byte lanes below it are ignored
  assign ap_idx = 8'(haddr[fslg_pkg::ADDR_W-1:fslg_pkg::IDX_LSB]);

  // field slices of the protection byte
  assign boot_area_guard = section_protection_fuses[fslg_pkg::BOOT_LSB +: 2];
  assign app_area_guard = section_protection_fuses[fslg_pkg::APP_LSB +: 2];
  assign app_table_guard = section_protection_fuses[fslg_pkg::TABLE_LSB +: 2];

  // data-phase bookkeeping for writes
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      dp_write <= 1'b0;
      dp_idx <= 8'h00;
    end
    else
    begin
      dp_write <= addr_phase & hwrite;
      dp_idx <= ap_idx;
    end
  end

  // read mux, decoded in the address phase so data stands in the data phase
  always_comb
  begin
    next_rdata = 32'h0000_0000;
    case (ap_idx)
      fslg_pkg::OPTION_IDX:
      begin
        next_rdata[7:0] = {fslg_pkg::OPTION_RESERVED, option_store};
      end
      fslg_pkg::PROTECT_IDX:
      begin
        next_rdata[7:0] = section_protection_fuses;
      end
      fslg_pkg::STATUS_IDX:
      begin
        next_rdata[fslg_pkg::ST_BUSY_BIT] = erase_busy;
        next_rdata[fslg_pkg::ST_PEND_BIT] = keep_pending;
        next_rdata[fslg_pkg::ST_KEEP_BIT] = keep_live;
      end
      default:
      begin
        // unmapped and write-only words read as zero
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read data register
  // held until the next read address phase, so a slow master still sees it
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      hrdata <= 32'h0000_0000;
    end
    else if (addr_phase && !hwrite)
    begin
      hrdata <= next_rdata;
    end
  end

  // option byte; writes ignored while an erase runs
  // limitation: the brownout select follows at once, with no write timeout
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      option_store <= fslg_pkg::OPTION_RESET[fslg_pkg::OPT_STORE_MSB:0];
    end
    else if (dp_write && dp_idx == fslg_pkg::OPTION_IDX && !erase_busy)
    begin
      option_store <= hwdata[fslg_pkg::OPT_STORE_MSB:0];
    end
  end

  // threshold select goes straight to the brownout detector
  assign brownout_threshold_sel = option_store[fslg_pkg::BOD_MSB:fslg_pkg::BOD_LSB];

  // keep value becomes live only once its write timeout has run out;
  // a fresh write restarts the timeout
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      keep_live <= fslg_pkg::OPTION_RESET[fslg_pkg::KEEP_BIT];
      keep_pending <= 1'b0;
      keep_cnt <= '0;
    end
    else if (dp_write && dp_idx == fslg_pkg::OPTION_IDX && !erase_busy)
    begin
      keep_pending <= 1'b1;
      keep_cnt <= fslg_pkg::CNT_W'(fslg_pkg::KEEP_TIMEOUT_CYC - 1);
    end
    else if (keep_pending)
    begin
      if (keep_cnt == '0)
      begin
        // live from here on, no programming-mode exit needed
        keep_live <= option_store[fslg_pkg::KEEP_BIT];
        keep_pending <= 1'b0;
      end
      else
      begin
        keep_cnt <= keep_cnt - 1'b1;
      end
    end
  end

  // protection byte: guards may only tighten, erase restores all ones
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      section_protection_fuses <= fslg_pkg::PROTECT_RESET;
    end
    else if (erase_state == fslg_pkg::ERASE_DONE)
    begin
      section_protection_fuses <= fslg_pkg::PROTECT_RESET;
    end
    else if (dp_write && dp_idx == fslg_pkg::PROTECT_IDX && !erase_busy)
    begin
      // and-ing only clears bits, so 11 -> 10/01 -> 00 and never back
      section_protection_fuses <= section_protection_fuses & ~(fslg_pkg::PROTECT_SW_MASK
        & ~hwdata[7:0]);
      if (prog_if_active)
      begin
        // only the programmer reaches the external field
        section_protection_fuses <= section_protection_fuses & hwdata[7:0];
      end
    end
  end

  // external field only feeds the programming side, never the access check
  assign external_access_guard = section_protection_fuses[fslg_pkg::EXT_LSB +: 2];

  // chip erase sequencer
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      erase_state <= fslg_pkg::ERASE_IDLE;
      erase_cnt <= '0;
      erase_keep <= 1'b0;
    end
    else
    begin
      case (erase_state)
        fslg_pkg::ERASE_IDLE:
        begin
          if (dp_write && dp_idx == fslg_pkg::ERASE_CTRL_IDX
              && hwdata[fslg_pkg::ERASE_GO_BIT])
          begin
            // the keep value live at the start rules the whole erase;
            // keep bit 1 means the eeprom goes along with the flash
            erase_keep <= keep_live;
            erase_cnt <= fslg_pkg::CNT_W'(fslg_pkg::ERASE_CYC - 1);
            erase_state <= fslg_pkg::ERASE_RUN;
          end
        end
        fslg_pkg::ERASE_RUN:
        begin
          if (erase_cnt == '0)
          begin
            erase_state <= fslg_pkg::ERASE_DONE;
          end
          else
          begin
            erase_cnt <= erase_cnt - 1'b1;
          end
        end
        fslg_pkg::ERASE_DONE:
        begin
          erase_state <= fslg_pkg::ERASE_IDLE;
        end
        default:
        begin
          erase_state <= fslg_pkg::ERASE_IDLE;
        end
      endcase
    end
  end

  // erase strobes held for the whole erase
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      erase_flash <= 1'b0;
      erase_eeprom <= 1'b0;
    end
    else
    begin
      erase_flash <= (erase_state == fslg_pkg::ERASE_RUN);
      erase_eeprom <= (erase_state == fslg_pkg::ERASE_RUN) && erase_keep;
    end
  end

  // busy covers the done cycle too, so no write races the unlock
  assign erase_busy = (erase_state != fslg_pkg::ERASE_IDLE);

  // guard of the section being touched
  always_comb
  begin
    case (acc_target)
      fslg_pkg::SEC_BOOT:
      begin
        target_guard = boot_area_guard;
      end
      fslg_pkg::SEC_TABLE:
      begin
        target_guard = app_table_guard;
      end
      default:
      begin
        target_guard = app_area_guard;
      end
    endcase
  end

  // access decision; the external guard takes no part here
  // a denied access still gets its answer, so the core never stalls
  always_comb
  begin
    next_allow = 1'b1;
    if (acc_store)
    begin
      // write-blocked and read-write-blocked both clear the store bit
      next_allow = target_guard[fslg_pkg::STORE_OK_BIT];
    end
    else if (!target_guard[fslg_pkg::LOAD_OK_BIT])
    begin
      // loads are only fenced off from the opposite section
      if (acc_target == fslg_pkg::SEC_BOOT)
      begin
        next_allow = exec_in_boot;
      end
      else
      begin
        next_allow = !exec_in_boot;
      end
    end
    if (erase_busy)
    begin
      // memory contents are in flux during erase
      next_allow = 1'b0;
    end
  end

  // interrupt mask for code running in the locked-off section
  always_comb
  begin
    next_mask = 1'b0;
    if (exec_in_boot && !ivec_in_boot && !boot_area_guard[fslg_pkg::LOAD_OK_BIT])
    begin
      next_mask = 1'b1;
    end
    if (!exec_in_boot && ivec_in_boot
        && (!app_area_guard[fslg_pkg::LOAD_OK_BIT] || !app_table_guard[fslg_pkg::LOAD_OK_BIT]))
    begin
      next_mask = 1'b1;
    end
  end

  // registered answers to the core, one cycle after the request
  // trade-off: one cycle of latency buys a short path from the guard bytes
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      acc_done <= 1'b0;
      acc_allow <= 1'b0;
      irq_mask <= 1'b0;
    end
    else
    begin
      acc_done <= acc_valid;
      acc_allow <= acc_valid & next_allow;
      irq_mask <= next_mask;
    end
  end

endmodule : fslg_guard

// ==== tb/fslg_core_model.sv ====
`timescale 1ns/100ps
// core side: issues one program-memory access per call
module fslg_core_model (
  // clock
  input wire logic ref_clk,
  // access request
  output logic acc_valid,
  output logic acc_store,
  output logic [1:0] acc_target,
  output logic exec_in_boot,
  output logic ivec_in_boot
);
  // idle at time zero
  initial
  begin
    acc_valid = 1'b0;
    acc_store = 1'b0;
    acc_target = 2'h0;
    exec_in_boot = 1'b0;
    ivec_in_boot = 1'b0;
  end
  // held for one sampling edge; store and target scrambled after so stale values never match
  task automatic req(input logic s, input logic [1:0] t, input logic e, input logic v);
    @(posedge ref_clk);
    acc_valid <= 1'b1;
    acc_store <= s;
    acc_target <= t;
    exec_in_boot <= e;
    ivec_in_boot <= v;
    @(posedge ref_clk);
    acc_valid <= 1'b0;
    acc_store <= ~s;
    acc_target <= ~t;
  endtask : req
endmodule : fslg_core_model

// ==== tb/fslg_guard_chk.sv ====
`timescale 1ns/100ps
// pin-level checks on the guard; guard bytes are not visible here
module fslg_guard_chk (
  // clock and reset
  input wire logic ref_clk,
  input wire logic sys_rst,
  // observed ports
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic acc_valid,
  input wire logic acc_done,
  input wire logic acc_allow,
  input wire logic exec_in_boot,
  input wire logic ivec_in_boot,
  input wire logic irq_mask,
  input wire logic prog_if_active,
  input wire logic erase_flash,
  input wire logic erase_eeprom,
  input wire logic erase_busy,
  input wire logic [1:0] external_access_guard
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (sys_rst);
  chk_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  chk_done_timing: assert property (acc_done == $past(acc_valid))
    else $error("access answer off its cycle");
  chk_allow_alone: assert property (!acc_done |-> !acc_allow)
    else $error("allow without answer");
  chk_busy_deny: assert property (acc_valid && erase_busy |=> !acc_allow)
    else $error("access allowed during erase");
  chk_irq_same: assert property (exec_in_boot == ivec_in_boot |=> !irq_mask)
    else $error("interrupts masked in vector section");
  chk_eeprom_flash: assert property (erase_eeprom |-> erase_flash)
    else $error("eeprom erase outside flash erase");
  chk_erase_start: assert property ($rose(erase_busy) |=> $rose(erase_flash))
    else $error("flash erase late");
  chk_erase_len: assert property ($rose(erase_flash) |-> ##199 erase_flash ##1 !erase_flash)
    else $error("flash erase length wrong");
  chk_unlock_done: assert property ($fell(erase_busy) |-> external_access_guard == 2'h3)
    else $error("guard not unlocked after erase");
  chk_ext_source: assert property ($changed(external_access_guard) |->
    $past(prog_if_active) || $past(erase_busy))
    else $error("external guard changed by software");
endmodule : fslg_guard_chk

bind fslg_guard fslg_guard_chk u_chk (.ref_clk(ref_clk), .sys_rst(sys_rst),
  .hreadyout(hreadyout), .hresp(hresp), .acc_valid(acc_valid), .acc_done(acc_done),
  .acc_allow(acc_allow), .exec_in_boot(exec_in_boot), .ivec_in_boot(ivec_in_boot),
  .irq_mask(irq_mask), .prog_if_active(prog_if_active), .erase_flash(erase_flash),
  .erase_eeprom(erase_eeprom), .erase_busy(erase_busy),
  .external_access_guard(external_access_guard));

// ==== tb/test_fslg_guard.sv ====
`timescale 1ns/100ps
module test_fslg_guard;
  // bench drive and results
  logic ref_clk, sys_rst, hsel, hwrite, prog_if_active, fl_d, rd_v;
  logic [11:0] haddr;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] hwdata, last;
  logic [7:0] prot, opt;
  logic [7:0] pv [4] = '{8'he7, 8'h93, 8'h4f, 8'h3b};
  logic [31:0] aq [$], rq [$], eq [$];
  int mismatches, samples_checked, seed, n, k;
  wire hreadyout, hresp, acc_valid, acc_store, exec_in_boot, ivec_in_boot, acc_done;
  wire acc_allow, irq_mask, erase_flash, erase_eeprom, erase_busy;
  wire [31:0] hrdata;
  wire [1:0] acc_target, external_access_guard;
  wire [2:0] brownout_threshold_sel;
  fslg_guard dut (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .prog_if_active(prog_if_active),
    .acc_valid(acc_valid), .acc_store(acc_store), .acc_target(acc_target),
    .exec_in_boot(exec_in_boot), .ivec_in_boot(ivec_in_boot), .acc_done(acc_done),
    .acc_allow(acc_allow), .irq_mask(irq_mask), .erase_flash(erase_flash),
    .erase_eeprom(erase_eeprom), .erase_busy(erase_busy),
    .brownout_threshold_sel(brownout_threshold_sel),
    .external_access_guard(external_access_guard));
  fslg_core_model core (.ref_clk(ref_clk), .acc_valid(acc_valid), .acc_store(acc_store),
    .acc_target(acc_target), .exec_in_boot(exec_in_boot), .ivec_in_boot(ivec_in_boot));
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  // byte address of a register index
  function automatic logic [11:0] ad(input logic [7:0] i);
    return {2'h0, i, 2'h0};
  endfunction : ad
  task automatic give_verdict();
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : give_verdict
  task automatic cmp(input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      mismatches++;
      $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask : cmp
  // bounded wait for hready at a rising edge
  task automatic rdy();
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 50);
    if (hreadyout !== 1'b1)
    begin
      mismatches++;
      give_verdict();
    end
  endtask : rdy
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b1;
    htrans <= 2'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rdy();
  endtask : wr
  // c set: expectation queued for the watcher
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input bit c);
    @(posedge ref_clk);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= 1'b0;
    htrans <= 2'h2;
    rdy();
    hsel <= 1'b0;
    htrans <= 2'h0;
    rd_v <= c;
    if (c)
      rq.push_back(e);
    rdy();
    last = hrdata;
    rd_v <= 1'b0;
  endtask : rd
  // random access; load refused only when read-locked and run from the other section, or when deny is set
  task automatic acc(input bit deny);
    logic [1:0] t, g;
    logic s, e, v, ok;
    s = $random(seed);
    t = 2'($unsigned($random(seed)) % 3);
    e = $random(seed);
    v = $random(seed);
    g = t == fslg_pkg::SEC_BOOT ? prot[7:6] : t == fslg_pkg::SEC_TABLE ? prot[3:2] : prot[5:4];
    ok = s ? g[0] : (g[1] || !(e ^ (t == fslg_pkg::SEC_BOOT)));
    aq.push_back({30'h0, (e & !v & !prot[7]) | (!e & v & !(prot[5] & prot[3])), ok & !deny});
    core.req(s, t, e, v);
  endtask : acc
  // watcher: oldest note against each result as it appears
  always @(posedge ref_clk)
  begin
    if (acc_done === 1'b1)
      cmp(aq.pop_front(), {30'h0, irq_mask, acc_allow});
    if (rd_v === 1'b1)
      cmp(rq.pop_front(), hrdata);
    if (erase_flash === 1'b1 && fl_d !== 1'b1)
      cmp(eq.pop_front(), {31'h0, erase_eeprom});
    fl_d <= erase_flash;
  end
  initial
  begin
    seed = 32'h7947;
    {hsel, hwrite, prog_if_active, fl_d, rd_v} = 5'h0;
    prot = 8'hff;
    {haddr, htrans, hsize, hwdata} = {12'h0, 2'h0, 3'h2, 32'h0};
    sys_rst = 1'b1;
    repeat (20) @(posedge ref_clk);
    sys_rst <= 1'b0;
    rd(ad(fslg_pkg::PROTECT_IDX), 32'hff, 1);
    rd(ad(fslg_pkg::OPTION_IDX), 32'hff, 1);
    rd(12'h030, 32'h0, 1);
    for (int i = 0; i < 4; i++)
    begin
      // new keep value, wait until live, then erase under it
      opt = {2'h3, 2'($random(seed)), i[0], 3'($random(seed))};
      wr(ad(fslg_pkg::OPTION_IDX), {24'h0, opt});
      rd(ad(fslg_pkg::OPTION_IDX), {24'h0, opt}, 1);
      cmp({29'h0, opt[2:0]}, {29'h0, brownout_threshold_sel});
      k = 0;
      do
      begin
        rd(ad(fslg_pkg::STATUS_IDX), 32'h0, 0);
        k++;
      end while (last[1] !== 1'b0 && k < 200);
      if (last[1] !== 1'b0)
      begin
        mismatches++;
        give_verdict();
      end
      cmp({31'h0, i[0]}, {31'h0, last[2]});
      eq.push_back({31'h0, i[0]});
      wr(ad(fslg_pkg::ERASE_CTRL_IDX), 32'h1);
      acc(1);
      k = 0;
      while (erase_busy !== 1'b0 && k < 400)
      begin
        @(negedge ref_clk);
        k++;
      end
      if (erase_busy !== 1'b0)
      begin
        mismatches++;
        give_verdict();
      end
      rd(ad(fslg_pkg::PROTECT_IDX), 32'hff, 1);
      wr(ad(fslg_pkg::PROTECT_IDX), {24'h0, pv[i]});
      wr(ad(fslg_pkg::PROTECT_IDX), 32'hff);
      prot = pv[i];
      rd(ad(fslg_pkg::PROTECT_IDX), {24'h0, pv[i]}, 1);
      repeat (24) acc(0);
      repeat (6) acc(0);
      if (i == 0)
      begin
        @(posedge ref_clk);
        prog_if_active <= 1'b1;
        wr(ad(fslg_pkg::PROTECT_IDX), 32'hfe);
        @(posedge ref_clk);
        prog_if_active <= 1'b0;
        rd(ad(fslg_pkg::PROTECT_IDX), {24'h0, pv[0] & 8'hfe}, 1);
        cmp(32'h2, {30'h0, external_access_guard});
        repeat (6) acc(0);
      end
      if (i == 3)
      begin
        wr(ad(fslg_pkg::PROTECT_IDX), 32'h0);
        rd(ad(fslg_pkg::PROTECT_IDX), 32'h03, 1);
      end
      $display("pass %0d done", i);
    end
    repeat (4) @(posedge ref_clk);
    give_verdict();
  end
endmodule : test_fslg_guard
